// ### core/icmtx_defs.vh
// Constants for the transmit stream port: bus fields, APB map, resets.
// Included by the transmit stream port and its buffer; definitions only.
`ifndef ICMTX_DEFS_VH
`define ICMTX_DEFS_VH

// Application bus field positions
`define ICMTX_BUS_W        75
`define ICMTX_DATA_MSB     63
`define ICMTX_EOP_BIT      72
`define ICMTX_SOP_BIT      73
`define ICMTX_ERR_BIT      74

// Buffer entry layout: {err, sop, eop, data}
`define ICMTX_ENT_W        67
`define ICMTX_ENT_EOP      64
`define ICMTX_ENT_SOP      65
`define ICMTX_ENT_ERR      66

// Buffer sizing and throttle margin (beats after ready falls)
`define ICMTX_BUF_DEPTH    8
`define ICMTX_SKID_BEATS   3
`define ICMTX_CRED_W       22

// APB register byte offsets
`define ICMTX_OFS_CTRL     8'h00
`define ICMTX_OFS_NPTHR    8'h04
`define ICMTX_OFS_STATUS   8'h08
`define ICMTX_OFS_CREDIT   8'h0C
`define ICMTX_OFS_PKTCNT   8'h10
`define ICMTX_OFS_ID       8'h14

// CTRL fields
`define ICMTX_CTRL_EN      0
`define ICMTX_CTRL_NPFORCE 1
`define ICMTX_CTRL_NPAUTO  2
`define ICMTX_CTRL_RST     3'h5

// STATUS fields
`define ICMTX_ST_OVF       8
`define ICMTX_ST_FRM       9
`define ICMTX_ST_INPKT     10
`define ICMTX_ST_MASK      11

// NPTHR reset: mask once this many beats are queued
`define ICMTX_NPTHR_RST    4'h6

// Block identity word, value arbitrary
`define ICMTX_ID_VAL       32'h0000_1C01

`endif

// ### core/icmtx_buf.v
// Small FIFO with valid/ready on both sides and an occupancy count.
// Assumes a single clock; writes when full are refused by in_ready low.
`timescale 1ns/10ps
`include "icmtx_defs.vh"

module icmtx_buf #(
    parameter W     = `ICMTX_ENT_W,
    parameter DEPTH = `ICMTX_BUF_DEPTH,
    parameter AW    = 3
) (
    input  wire          clk,       // system clock
    input  wire          rst_n,     // async reset, active low
    input  wire          in_valid,  // write request
    output wire          in_ready,  // space available
    input  wire [W-1:0]  in_data,   // write entry
    output wire          out_valid, // entry available
    input  wire          out_ready, // drain accepts
    output wire [W-1:0]  out_data,  // head entry
    output wire [AW:0]   level      // entries held
);

    reg [W-1:0]  mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_q;
    reg [AW-1:0] rd_ptr_q;
    reg [AW:0]   cnt_q;
    wire         do_wr;
    wire         do_rd;

    assign in_ready  = (cnt_q != DEPTH[AW:0]);
    assign out_valid = (cnt_q != {(AW+1){1'b0}});
    assign do_wr     = in_valid & in_ready;
    assign do_rd     = out_valid & out_ready;
    assign out_data  = mem[rd_ptr_q];
    assign level     = cnt_q;

    // Storage has no reset; only pointers and count are control state
    always @(posedge clk) begin
        if (do_wr) begin
            mem[wr_ptr_q] <= in_data;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_q <= {AW{1'b0}};
            rd_ptr_q <= {AW{1'b0}};
            cnt_q    <= {(AW+1){1'b0}};
        end else begin
            if (do_wr) begin
                wr_ptr_q <= (wr_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                               : wr_ptr_q + 1'b1;
            end
            if (do_rd) begin
                rd_ptr_q <= (rd_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                               : rd_ptr_q + 1'b1;
            end
            if (do_wr & ~do_rd) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (do_rd & ~do_wr) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end

endmodule

// ### core/icmtx_port.v
// Transmit stream port: application beats in, protocol core beats out.
// Assumes one clock for application, core and APB; core side is
// valid/ready; APB master follows the usual setup/access sequence.
`timescale 1ns/10ps
`include "icmtx_defs.vh"

// Summary of operation
// - Descriptor halves then payload, kept in order
// - Error bit forwarded to core unchanged
// - Ready high while more than SKID slots free, low to throttle
// - Core credit count registered, one-cycle lag
// - Credit count not adjusted for queued beats
// - Mask output throttles non-posted requests
// - Beat captured every edge valid is high and the buffer has room
module icmtx_port #(
    parameter DEPTH  = `ICMTX_BUF_DEPTH,
    parameter AW     = 3,
    parameter SKID   = `ICMTX_SKID_BEATS,
    parameter CRED_W = `ICMTX_CRED_W
) (
    input  wire                  clk,                // system clock, 50 MHz
    input  wire                  rst_n,              // async reset, active low
    input  wire                  app_tx_valid,       // application beat valid
    input  wire [74:0]           app_tx_bus,         // application beat
    output wire                  bridge_tx_ready,    // room for more beats
    output wire                  nonposted_mask_out, // hold off non-posted requests
    output reg  [CRED_W-1:0]     app_credit_q,       // credit count toward application
    output wire                  core_tx_valid,      // beat toward core valid
    input  wire                  core_tx_ready,      // core takes beat
    output wire [63:0]           core_tx_data,       // descriptor or payload word
    output wire                  core_tx_sop,        // first beat of packet
    output wire                  core_tx_eop,        // last beat of packet
    output wire                  core_tx_err,        // packet error toward core
    input  wire [CRED_W-1:0]     core_credit_count,  // core available credits
    input  wire                  psel,               // APB select
    input  wire                  penable,            // APB access phase
    input  wire                  pwrite,             // APB write
    input  wire [7:0]            paddr,              // APB byte address
    input  wire [31:0]           pwdata,             // APB write data
    output wire                  pready,             // APB ready
    output reg  [31:0]           prdata,             // APB read data
    output wire                  pslverr             // APB error
);

    localparam [AW:0] DEPTH_L = DEPTH;
    localparam [AW:0] SKID_L  = SKID;

    reg  [2:0]             ctrl_q;
    reg  [3:0]             npthr_q;
    reg                    ovf_q;
    reg                    frm_q;
    reg                    in_pkt_q;
    reg  [15:0]            pkt_cnt_q;
    reg  [AW:0]            max_lvl_q;
    wire                   buf_in_ready;
    wire                   buf_out_valid;
    wire [`ICMTX_ENT_W-1:0] buf_in_data;
    wire [`ICMTX_ENT_W-1:0] buf_out_data;
    wire [AW:0]            level;
    wire [AW:0]            free_slots;
    wire                   beat_in;
    wire                   beat_out;
    wire                   in_sop;
    wire                   in_eop;
    wire                   frm_evt;
    wire                   ovf_evt;
    wire                   np_auto;
    wire                   apb_wr;
    wire                   apb_setup;
    wire                   addr_ok;
    wire                   wr_status;
    reg  [31:0]            rd_mux;

    assign beat_in = app_tx_valid & buf_in_ready;
    // Only reachable if the application overruns its 3-cycle allowance
    assign ovf_evt = app_tx_valid & ~buf_in_ready;

    assign buf_in_data = {app_tx_bus[`ICMTX_ERR_BIT],
                          app_tx_bus[`ICMTX_SOP_BIT],
                          app_tx_bus[`ICMTX_EOP_BIT],
                          app_tx_bus[`ICMTX_DATA_MSB:0]};

    // depth leaves SKID slots after ready falls
    icmtx_buf #(
        .W     (`ICMTX_ENT_W),
        .DEPTH (DEPTH),
        .AW    (AW)
    ) u_buf (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_valid  (app_tx_valid),
        .in_ready  (buf_in_ready),
        .in_data   (buf_in_data),
        .out_valid (buf_out_valid),
        .out_ready (core_tx_ready & ctrl_q[`ICMTX_CTRL_EN]),
        .out_data  (buf_out_data),
        .level     (level)
    );

    assign free_slots = DEPTH_L - level;

    // ready while more than SKID slots free
    // up to 3 late beats still fit
    assign bridge_tx_ready = (free_slots > SKID_L);

    // Disabled forwarding parks beats in the buffer; ready then falls
    assign core_tx_valid = buf_out_valid & ctrl_q[`ICMTX_CTRL_EN];
    assign beat_out      = core_tx_valid & core_tx_ready;
    assign core_tx_data  = buf_out_data[`ICMTX_DATA_MSB:0];
    assign core_tx_sop   = buf_out_data[`ICMTX_ENT_SOP];
    assign core_tx_eop   = buf_out_data[`ICMTX_ENT_EOP];
    assign core_tx_err   = buf_out_data[`ICMTX_ENT_ERR];

    // beat without start flag outside a packet is a framing fault
    // start flag inside a packet is a framing fault
    assign in_sop  = app_tx_bus[`ICMTX_SOP_BIT];
    assign in_eop  = app_tx_bus[`ICMTX_EOP_BIT];
    assign frm_evt = beat_in & ((in_sop & in_pkt_q) | (~in_sop & ~in_pkt_q));

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            in_pkt_q <= 1'b0;
        end else if (beat_in) begin
            in_pkt_q <= ~in_eop;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pkt_cnt_q <= 16'h0000;
        end else if (beat_out & core_tx_eop) begin
            pkt_cnt_q <= pkt_cnt_q + 16'h0001;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            max_lvl_q <= {(AW+1){1'b0}};
        end else if (level > max_lvl_q) begin
            max_lvl_q <= level;
        end
    end

    // raw core value, no local adjustment
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            app_credit_q <= {CRED_W{1'b0}};
        end else begin
            app_credit_q <= core_credit_count;
        end
    end

    // mask by software or by queue depth
    assign np_auto = ctrl_q[`ICMTX_CTRL_NPAUTO] & ({{(4-AW){1'b0}}, level} >= {1'b0, npthr_q});
    assign nonposted_mask_out = ctrl_q[`ICMTX_CTRL_NPFORCE] | np_auto;

    // APB slave: zero wait states, read data sampled at setup
    assign apb_setup = psel & ~penable;
    assign apb_wr    = psel & penable & pwrite;
    assign addr_ok   = (paddr == `ICMTX_OFS_CTRL)   | (paddr == `ICMTX_OFS_NPTHR) |
                       (paddr == `ICMTX_OFS_STATUS) | (paddr == `ICMTX_OFS_CREDIT) |
                       (paddr == `ICMTX_OFS_PKTCNT) | (paddr == `ICMTX_OFS_ID);
    assign pready    = 1'b1;
    assign pslverr   = psel & penable & ~addr_ok;
    assign wr_status = apb_wr & (paddr == `ICMTX_OFS_STATUS);

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q  <= `ICMTX_CTRL_RST;
            npthr_q <= `ICMTX_NPTHR_RST;
        end else if (apb_wr) begin
            if (paddr == `ICMTX_OFS_CTRL) begin
                ctrl_q <= pwdata[2:0];
            end
            if (paddr == `ICMTX_OFS_NPTHR) begin
                npthr_q <= pwdata[3:0];
            end
        end
    end

    // Sticky faults: write one to clear, a new event wins over the clear
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ovf_q <= 1'b0;
            frm_q <= 1'b0;
        end else begin
            if (ovf_evt) begin
                ovf_q <= 1'b1;
            end else if (wr_status & pwdata[`ICMTX_ST_OVF]) begin
                ovf_q <= 1'b0;
            end
            if (frm_evt) begin
                frm_q <= 1'b1;
            end else if (wr_status & pwdata[`ICMTX_ST_FRM]) begin
                frm_q <= 1'b0;
            end
        end
    end

    always @* begin
        rd_mux = 32'h0000_0000;
        case (paddr)
            `ICMTX_OFS_CTRL: begin
                rd_mux[2:0] = ctrl_q;
            end
            `ICMTX_OFS_NPTHR: begin
                rd_mux[3:0] = npthr_q;
            end
            `ICMTX_OFS_STATUS: begin
                rd_mux[AW:0]               = level;
                rd_mux[AW+4:4]             = max_lvl_q;
                rd_mux[`ICMTX_ST_OVF]      = ovf_q;
                rd_mux[`ICMTX_ST_FRM]      = frm_q;
                rd_mux[`ICMTX_ST_INPKT]    = in_pkt_q;
                rd_mux[`ICMTX_ST_MASK]     = nonposted_mask_out;
            end
            `ICMTX_OFS_CREDIT: begin
                rd_mux[CRED_W-1:0] = app_credit_q;
            end
            `ICMTX_OFS_PKTCNT: begin
                rd_mux[15:0] = pkt_cnt_q;
            end
            `ICMTX_OFS_ID: begin
                rd_mux = `ICMTX_ID_VAL;
            end
            default: begin
                rd_mux = 32'h0000_0000;
            end
        endcase
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
        end else if (apb_setup & ~pwrite) begin
            prdata <= rd_mux;
        end
    end

endmodule

// ### bench/icmtx_checker.sv
// Concurrent checks on the transmit stream port's pins.
// Assumes EN and NPAUTO stay set and the source never overfills.
`timescale 1ns/10ps
`include "icmtx_defs.vh"
module icmtx_checker #(
    parameter DEPTH  = 8,
    parameter SKID   = 3,
    parameter CRED_W = 22
) (
    input wire              clk,                // system clock
    input wire              rst_n,              // async reset
    input wire              app_tx_valid,       // beat in
    input wire              bridge_tx_ready,    // room flag
    input wire              nonposted_mask_out, // mask
    input wire [CRED_W-1:0] app_credit_q,       // credit out
    input wire [CRED_W-1:0] core_credit_count,  // credit in
    input wire              core_tx_valid,      // beat out
    input wire              core_tx_ready,      // core takes
    input wire [63:0]       core_tx_data,       // word out
    input wire              core_tx_sop,        // first flag
    input wire              core_tx_eop,        // last flag
    input wire              core_tx_err,        // error flag
    input wire              psel,               // APB select
    input wire              penable,            // APB access
    input wire [7:0]        paddr,              // APB address
    input wire              pready,             // APB ready
    input wire              pslverr             // APB error
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Shadow of buffer occupancy, from handshakes alone
    reg [4:0] occ_q;
    always @(posedge clk or negedge rst_n)
        if (!rst_n) occ_q <= 5'h0;
        else occ_q <= occ_q + app_tx_valid - (core_tx_valid && core_tx_ready);
    sequence s_stall; core_tx_valid && !core_tx_ready; endsequence
    sequence s_last; core_tx_valid && core_tx_ready && core_tx_eop; endsequence
    a_stall_hold: assert property (s_stall |=>
        $stable({core_tx_data, core_tx_sop, core_tx_eop, core_tx_err}))
        else $error("core beat changed while stalled");
    a_next_sop: assert property (s_last ##1 core_tx_valid |-> core_tx_sop)
        else $error("packet after last beat lacks start flag");
    a_ready_room: assert property (bridge_tx_ready == (DEPTH - occ_q > SKID))
        else $error("ready does not match free room");
    a_beat_shows: assert property (app_tx_valid |=> core_tx_valid)
        else $error("captured beat not offered to core");
    a_out_valid: assert property (core_tx_valid == (occ_q != 5'h0))
        else $error("core valid disagrees with occupancy");
    a_credit_lag: assert property (app_credit_q == $past(core_credit_count))
        else $error("credit not one cycle behind core");
    a_mask_auto: assert property (occ_q >= `ICMTX_NPTHR_RST |-> nonposted_mask_out)
        else $error("mask low with deep buffer");
    a_apb_ready: assert property (psel && penable |-> pready)
        else $error("APB access not answered");
    a_slverr_map: assert property (psel && penable && paddr > 8'h14 |-> pslverr)
        else $error("unmapped access not refused");
endmodule

// ### bench/icmtx_app_model.sv
// Application-side packet source for the transmit stream port.
// Assumes the bench calls send and idle; ready sampled on falling edge.
`timescale 1ns/10ps
module icmtx_app_model (
    input  wire        clk,             // system clock
    input  wire        bridge_tx_ready, // port has room
    output reg         app_tx_valid,    // beat valid
    output reg  [74:0] app_tx_bus       // beat
);
    integer low_q;
    initial begin
        app_tx_valid = 1'b0;
        app_tx_bus   = 75'h0;
    end
    // Mid-cycle sample avoids racing the port's edge
    always @(negedge clk)
        low_q <= bridge_tx_ready ? 0 : low_q + 1;
    task send(input integer n, input [63:0] base, input e, input integer lag);
        integer k;
        integer t;
        begin
            k = 0;
            t = 0;
            // Bounded so a stuck ready cannot hang the run
            while (k < n && t < 300) begin
                @(posedge clk);
                t = t + 1;
                // at most lag beats after ready falls
                if (low_q < lag) begin
                    app_tx_valid <= 1'b1;
                    app_tx_bus <= {e, k == 0, k == n - 1, 8'hA5 ^ k[7:0], base + k};
                    k = k + 1;
                end else begin
                    app_tx_valid <= 1'b0;
                    app_tx_bus   <= ~app_tx_bus;
                end
            end
        end
    endtask
    task idle;
        begin
            @(posedge clk);
            app_tx_valid <= 1'b0;
            app_tx_bus   <= ~app_tx_bus;
        end
    endtask
endmodule

// ### bench/tb.sv
// Self-checking bench for the transmit stream port.
// Assumes the port's reset values; core side and APB driven here.
`timescale 1ns/10ps
`include "icmtx_defs.vh"
module tb;
    reg         clk, rst_n, core_tx_ready, psel, penable, pwrite;
    reg  [7:0]  paddr;
    reg  [31:0] pwdata, r;
    reg  [21:0] core_credit_count;
    reg  [1:0]  mode;
    reg         e;
    wire        app_tx_valid, bridge_tx_ready, nonposted_mask_out, core_tx_valid;
    wire        core_tx_sop, core_tx_eop, core_tx_err, pready, pslverr;
    wire [74:0] app_tx_bus;
    wire [21:0] app_credit_q;
    wire [63:0] core_tx_data;
    wire [31:0] prdata;
    integer     miscompares, total_checks;
    logic [66:0] expq[$];
    icmtx_app_model app (.clk(clk), .bridge_tx_ready(bridge_tx_ready),
        .app_tx_valid(app_tx_valid), .app_tx_bus(app_tx_bus));
    icmtx_port dut (.clk(clk), .rst_n(rst_n), .app_tx_valid(app_tx_valid),
        .app_tx_bus(app_tx_bus), .bridge_tx_ready(bridge_tx_ready),
        .nonposted_mask_out(nonposted_mask_out), .app_credit_q(app_credit_q),
        .core_tx_valid(core_tx_valid), .core_tx_ready(core_tx_ready),
        .core_tx_data(core_tx_data), .core_tx_sop(core_tx_sop), .core_tx_eop(core_tx_eop),
        .core_tx_err(core_tx_err), .core_credit_count(core_credit_count), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr));
    task check(input string name, input [66:0] seen, input [66:0] exp);
        begin
            total_checks = total_checks + 1;
            if (seen !== exp) begin
                miscompares = miscompares + 1;
                $display("mismatch %s expected %h seen %h", name, exp, seen);
            end
        end
    endtask
    task complete_run;
        begin
            $display("checks %0d mismatches %0d", total_checks, miscompares);
            if (miscompares == 0 && total_checks > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    task expect_pkt(input integer n, input [63:0] base, input err);
        integer k;
        for (k = 0; k < n; k++) expq.push_back({err, k == 0, k == n - 1, base + k});
    endtask
    task drain;
        integer i;
        begin
            i = 0;
            while (expq.size() != 0 && i < 300) begin @(posedge clk); i++; end
            check("drain left", expq.size(), 0);
            if (expq.size() != 0) complete_run;
        end
    endtask
    task apb(input w, input [7:0] a, input [31:0] d);
        integer i;
        begin
            @(posedge clk);
            {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
            @(posedge clk);
            penable <= 1'b1;
            i = 0;
            do begin @(posedge clk); i++; end while (pready !== 1'b1 && i < 50);
            r = prdata;
            e = pslverr;
            {psel, penable} <= 2'b00;
            check("apb wait", i < 50, 1);
            if (i >= 50) complete_run;
        end
    endtask
    always @(posedge clk)
        core_tx_ready <= mode == 0 ? 1'b1 : mode == 1 ? ~core_tx_ready : 1'b0;
    // Core-side scoreboard, sampled before the edge's updates land
    always @(posedge clk) if (rst_n && core_tx_valid && core_tx_ready) begin
        if (expq.size() == 0) check("spare beat", 1, 0);
        else check("core beat", {core_tx_err, core_tx_sop, core_tx_eop, core_tx_data},
            expq.pop_front());
    end
    task t_stream;
        begin
            mode = 0;
            expect_pkt(5, 64'h1000, 1'b0);
            expect_pkt(3, 64'h2000, 1'b1);
            app.send(5, 64'h1000, 1'b0, 3);
            app.send(3, 64'h2000, 1'b1, 3);
            app.idle;
            drain;
            $display("test stream done");
        end
    endtask
    task t_fill;
        begin
            mode = 2;
            expect_pkt(9, 64'h3000, 1'b0);
            fork begin app.send(9, 64'h3000, 1'b0, 3); app.idle; end join_none
            repeat (14) @(negedge clk);
            check("ready full", bridge_tx_ready, 0);
            check("mask full", nonposted_mask_out, 1);
            @(posedge clk) core_credit_count <= 22'h2ABCD;
            @(negedge clk) check("credit early", app_credit_q, 0);
            @(negedge clk) check("credit late", app_credit_q, 22'h2ABCD);
            mode = 1;
            drain;
            @(negedge clk) check("ready empty", bridge_tx_ready, 1);
            check("mask empty", nonposted_mask_out, 0);
            $display("test fill done");
        end
    endtask
    task t_apb;
        begin
            apb(0, `ICMTX_OFS_ID, 0);
            check("id", r, `ICMTX_ID_VAL);
            check("mapped err", e, 0);
            apb(0, `ICMTX_OFS_CTRL, 0);
            check("ctrl reset", r, 32'h5);
            apb(1, `ICMTX_OFS_CTRL, 32'h7);
            @(negedge clk) check("mask forced", nonposted_mask_out, 1);
            apb(1, `ICMTX_OFS_CTRL, 32'h5);
            @(negedge clk) check("mask freed", nonposted_mask_out, 0);
            apb(0, `ICMTX_OFS_CREDIT, 0);
            check("credit reg", r, 32'h0002_ABCD);
            apb(0, `ICMTX_OFS_PKTCNT, 0);
            check("packets sent", r, 32'h0000_0003);
            apb(0, `ICMTX_OFS_STATUS, 0);
            check("status", r, 32'h0000_0080);
            apb(0, `ICMTX_OFS_NPTHR, 0);
            check("npthr reset", r, 32'h0000_0006);
            apb(0, 8'h20, 0);
            check("unmapped err", e, 1);
            check("unmapped data", r, 0);
            $display("test apb done");
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        {rst_n, psel, penable, pwrite, paddr, pwdata} = 0;
        core_credit_count = 22'h0;
        mode = 0;
        miscompares = 0;
        total_checks = 0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        t_stream;
        t_fill;
        t_apb;
        complete_run;
    end
endmodule
bind icmtx_port icmtx_checker #(.DEPTH(DEPTH), .SKID(SKID), .CRED_W(CRED_W)) chk (
    .clk(clk), .rst_n(rst_n), .app_tx_valid(app_tx_valid),
    .bridge_tx_ready(bridge_tx_ready), .nonposted_mask_out(nonposted_mask_out),
    .app_credit_q(app_credit_q), .core_credit_count(core_credit_count),
    .core_tx_valid(core_tx_valid), .core_tx_ready(core_tx_ready),
    .core_tx_data(core_tx_data), .core_tx_sop(core_tx_sop), .core_tx_eop(core_tx_eop),
    .core_tx_err(core_tx_err), .psel(psel), .penable(penable), .paddr(paddr),
    .pready(pready), .pslverr(pslverr));
